// file: hdl/dmjp_port.sv
// dual-mode programming port: test access port sampled by the system clock,
// sharing four pins with user i/o; pins and enables arrive from outside the clock domain
`default_nettype none
`include "dmjp_params.svh"
module dmjp_port (
    input wire logic clock,
    input wire logic rst,
    input wire logic legacy_variant,
    input wire logic test_port_enable,
    input wire logic program_supervoltage_enable,
    input wire dmjp_pkg::dmjp_pins_t pin_in,
    output logic [`DMJP_PINS-1:0] pin_out,
    output logic [`DMJP_PINS-1:0] pin_oe,
    input wire dmjp_pkg::dmjp_pins_t user_out,
    input wire dmjp_pkg::dmjp_pins_t user_oe,
    output dmjp_pkg::dmjp_pins_t user_in,
    input wire dmjp_pkg::dmjp_word_t capture_word,
    output dmjp_pkg::dmjp_word_t program_word,
    output logic program_strobe,
    output logic port_active
);
    import dmjp_pkg::*;

    dmjp_pins_t pin_s1_r, pin_s2_r;
    logic en_s1_r, en_s2_r, sv_s1_r, sv_s2_r, tck_s3_r;
    dmjp_pins_t user_in_r;
    dmjp_tap_e state_r, state_nxt;
    dmjp_ir_t ir_r, ir_nxt, irsh_r, irsh_nxt;
    dmjp_word_t dr_r, dr_nxt, word_r, word_nxt;
    logic byp_r, byp_nxt, tdo_r, tdo_nxt, strobe_r, strobe_nxt;
    logic port_mode, tck_rise, tck_fall, tms, tdi;

    // pin and enable synchronisers; logic reads the second stage, plus a third test clock stage for edge detection and a third pin stage for user_in
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
            en_s1_r <= 1'b0;
            en_s2_r <= 1'b0;
            sv_s1_r <= 1'b0;
            sv_s2_r <= 1'b0;
            tck_s3_r <= 1'b0;
            user_in_r <= 4'h0;
        end
        else
        begin
            pin_s1_r <= pin_in;
            pin_s2_r <= pin_s1_r;
            en_s1_r <= test_port_enable;
            en_s2_r <= en_s1_r;
            sv_s1_r <= program_supervoltage_enable;
            sv_s2_r <= sv_s1_r;
            tck_s3_r <= pin_s2_r[`DMJP_PIN_TCK];
            user_in_r <= pin_s2_r;
        end
    end

    assign port_mode = legacy_variant ? sv_s2_r : en_s2_r;
    assign tck_rise = port_mode & pin_s2_r[`DMJP_PIN_TCK] & ~tck_s3_r;
    assign tck_fall = port_mode & ~pin_s2_r[`DMJP_PIN_TCK] & tck_s3_r;
    assign tms = pin_s2_r[`DMJP_PIN_TMS];
    assign tdi = pin_s2_r[`DMJP_PIN_TDI];

    function automatic dmjp_tap_e tap_step(input dmjp_tap_e s, input logic m);
        case (s)
            TAP_RESET: tap_step = m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_step = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_step = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tap_step = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tap_step = m ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_step = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tap_step = m ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_step = m ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_step = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tap_step = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tap_step = m ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_step = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tap_step = m ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
            default: tap_step = TAP_RESET;
        endcase
    endfunction

    always_comb
    begin
        state_nxt = state_r;
        ir_nxt = ir_r;
        irsh_nxt = irsh_r;
        dr_nxt = dr_r;
        word_nxt = word_r;
        byp_nxt = byp_r;
        tdo_nxt = tdo_r;
        strobe_nxt = 1'b0;
        if (!port_mode)
        begin
            state_nxt = TAP_RESET;
            ir_nxt = `DMJP_IR_RESET;
        end
        else if (tck_rise)
        begin
            state_nxt = tap_step(state_r, tms);
            case (state_r)
                TAP_RESET: ir_nxt = `DMJP_IR_RESET;
                TAP_CAP_DR:
                begin
                    byp_nxt = 1'b0;
                    if (ir_r == `DMJP_IR_CAPTURE)
                        dr_nxt = capture_word;
                end
                TAP_SHIFT_DR:
                begin
                    byp_nxt = tdi;
                    if (ir_r == `DMJP_IR_PROGRAM || ir_r == `DMJP_IR_CAPTURE)
                        dr_nxt = {tdi, dr_r[`DMJP_PROG_W-1:1]};
                end
                TAP_UPD_DR:
                begin
                    if (ir_r == `DMJP_IR_PROGRAM)
                    begin
                        word_nxt = dr_r;
                        strobe_nxt = 1'b1;
                    end
                end
                TAP_CAP_IR: irsh_nxt = 4'h1;
                TAP_SHIFT_IR: irsh_nxt = {tdi, irsh_r[`DMJP_IR_W-1:1]};
                TAP_UPD_IR: ir_nxt = irsh_r;
                default: ;
            endcase
        end
        else if (tck_fall)
        begin
            // output only moves after the falling edge
            if (state_r == TAP_SHIFT_IR)
                tdo_nxt = irsh_r[0];
            else if (state_r == TAP_SHIFT_DR)
                tdo_nxt = (ir_r == `DMJP_IR_BYPASS) ? byp_r : dr_r[0];
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_r <= TAP_RESET;
            ir_r <= `DMJP_IR_RESET;
            irsh_r <= 4'h0;
            dr_r <= 32'h0;
            word_r <= 32'h0;
            byp_r <= 1'b0;
            tdo_r <= 1'b0;
            strobe_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            ir_r <= ir_nxt;
            irsh_r <= irsh_nxt;
            dr_r <= dr_nxt;
            word_r <= word_nxt;
            byp_r <= byp_nxt;
            tdo_r <= tdo_nxt;
            strobe_r <= strobe_nxt;
        end
    end

    always_comb
    begin
        if (port_mode)
        begin
            pin_oe = `DMJP_PORT_OE;
            pin_out = {tdo_r, 3'h0};
        end
        else
        begin
            pin_oe = user_oe;
            pin_out = user_out;
        end
    end

    assign user_in = user_in_r;
    assign program_word = word_r;
    assign program_strobe = strobe_r;
    assign port_active = port_mode;

    sequence s_rise_shift_dr;
        tck_rise && state_r == TAP_SHIFT_DR;
    endsequence

    a_tdo_after_fall: assert property (@(posedge clock) disable iff (rst)
        $changed(tdo_r) |-> $past(tck_fall)) else $error("serial output moved without a falling edge");
    a_tdo_hold_rise: assert property (@(posedge clock) disable iff (rst)
        tck_rise |=> $stable(tdo_r)) else $error("serial output moved on a rising edge");
    a_tdo_on_pin: assert property (@(posedge clock) disable iff (rst)
        port_mode |-> pin_out[`DMJP_PIN_TDO] == tdo_r) else $error("serial output not on pin");
    a_prog_shift_in: assert property (@(posedge clock) disable iff (rst)
        s_rise_shift_dr and ir_r == `DMJP_IR_PROGRAM |=> dr_r[`DMJP_PROG_W-1] == $past(tdi))
        else $error("serial input bit not shifted in");
    a_bypass_chain: assert property (@(posedge clock) disable iff (rst)
        s_rise_shift_dr ##1 (!tck_rise)[*1] |-> byp_r == $past(tdi)) else $error("bypass bit lost");
    a_tap_capture: assert property (@(posedge clock) disable iff (rst)
        tck_rise && state_r == TAP_CAP_DR && !tms |=> state_r == TAP_SHIFT_DR)
        else $error("controller did not enter shift");
    a_tap_reset_hold: assert property (@(posedge clock) disable iff (rst)
        tck_rise && state_r == TAP_RESET && tms |=> state_r == TAP_RESET) else $error("controller left reset");
    a_port_pins: assert property (@(posedge clock) disable iff (rst)
        port_mode |-> pin_oe == `DMJP_PORT_OE) else $error("test pins not in port function");
    a_user_pins: assert property (@(posedge clock) disable iff (rst)
        !port_mode |-> pin_oe == user_oe ##1 state_r == TAP_RESET) else $error("user i/o not selected");
    a_legacy_sv: assert property (@(posedge clock) disable iff (rst)
        legacy_variant && !sv_s2_r |-> !port_mode && pin_oe == user_oe)
        else $error("older variant enabled without supervoltage");
endmodule
`default_nettype wire

// file: pkg/dmjp_params.svh
// constants for the dual-mode programming port
// assumes inclusion by bare name from the package and the port module
`ifndef DMJP_PARAMS_SVH
`define DMJP_PARAMS_SVH
`define DMJP_PINS 4
`define DMJP_PIN_TCK 0
`define DMJP_PIN_TMS 1
`define DMJP_PIN_TDI 2
`define DMJP_PIN_TDO 3
`define DMJP_PORT_OE 4'h8
`define DMJP_IR_W 4
`define DMJP_IR_RESET 4'hf
`define DMJP_IR_BYPASS 4'hf
`define DMJP_IR_PROGRAM 4'h2
`define DMJP_IR_CAPTURE 4'h1
`define DMJP_PROG_W 32
`define DMJP_CLK_NS 5
`define DMJP_LINK_NS 125
`define DMJP_LINK_CYC (`DMJP_LINK_NS / `DMJP_CLK_NS)
`endif

// file: pkg/dmjp_pkg.sv
// types for the dual-mode programming port
// assumes dmjp_params.svh is on the include path
`default_nettype none
`include "dmjp_params.svh"
package dmjp_pkg;
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR,
        TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
        TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } dmjp_tap_e;
    typedef logic [`DMJP_IR_W-1:0] dmjp_ir_t;
    typedef logic [`DMJP_PROG_W-1:0] dmjp_word_t;
    typedef logic [`DMJP_PINS-1:0] dmjp_pins_t;
endpackage
`default_nettype wire

// file: verification/dmjp_prog_source.sv
// programming source model: drives test clock, mode and serial data, reads serial output
// assumes the bench ties its pins to the shared-pin wires and calls its tasks
`default_nettype none
module dmjp_prog_source (
    input wire logic clock,
    input wire logic en,
    input wire logic tdo,
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic programming_active_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // low whenever en is high, even when the older variant leaves the port disabled without supervoltage
    assign programming_active_n = ~en;
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one test clock period of 25 system clocks; test clock idles low between frames
    task automatic step(input logic m, input logic d, output logic q);
        @(negedge clock);
        tms = m;
        tdi = d;
        repeat (11) @(negedge clock);
        q = tdo;
        tck = 1'b1;
        repeat (13) @(negedge clock);
        tck = 1'b0;
    endtask
    task automatic tmsseq(input logic [7:0] s, input int n);
        logic b;
        for (int i = 0; i < n; i++)
            step(s[i], 1'b0, b);
    endtask
    task automatic shift(input int n, input logic [31:0] d, output logic [31:0] q);
        logic b;
        q = '0;
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, d[i], b);
            q[i] = b;
        end
    endtask
endmodule
`default_nettype wire

// file: verification/test_dmjp_port.sv
// self-checking bench for the dual-mode programming port
// assumes dmjp_pkg and the source model are compiled first
`default_nettype none
module test_dmjp_port;
    timeunit 1ns;
    timeprecision 100ps;
    import dmjp_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic legacy_variant = 1'b0;
    logic supv = 1'b0;
    logic en = 1'b0;
    logic tdo_tgl = 1'b0;
    logic [3:0] pin_out, pin_oe;
    dmjp_pins_t pin_in, user_out = '0, oe_rnd = '0, user_oe, user_in;
    dmjp_word_t capture_word = '0, program_word;
    logic program_strobe, port_active, tck, tms, tdi, active_n;
    logic [31:0] q, w, e;
    logic mq[$];
    int num_errors = 0, n_tests = 0, strobes = 0, cycles = 0, s0;
    // released pins show the source's drive, or a toggling pattern on the tdo pin, rather than their last value
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & {tdo_tgl, tdi, tms, tck});
    assign user_oe = active_n ? oe_rnd : 4'h0;
    dmjp_port uut (.clock(clock), .rst(rst), .legacy_variant(legacy_variant), .test_port_enable(en),
        .program_supervoltage_enable(supv), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .user_out(user_out), .user_oe(user_oe), .user_in(user_in), .capture_word(capture_word),
        .program_word(program_word), .program_strobe(program_strobe), .port_active(port_active));
    dmjp_prog_source src (.clock(clock), .en(en), .tdo(pin_in[3]), .tck(tck), .tms(tms), .tdi(tdi),
        .programming_active_n(active_n));
    initial
        forever #2.5 clock = ~clock;
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cycles++;
        tdo_tgl <= ~tdo_tgl;
        if (program_strobe === 1'b1)
            strobes++;
        if (cycles == 10000)
        begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic load_ir(input logic [3:0] ir);
        src.tmsseq(8'h03, 4);
        src.shift(4, {28'h0, ir}, q);
        check(q[3:0], 4'h1, "instruction capture");
        src.tmsseq(8'h01, 2);
    endtask
    task automatic dr(input int n, input logic [31:0] d);
        src.tmsseq(8'h01, 3);
        src.shift(n, d, q);
        src.tmsseq(8'h01, 2);
    endtask
    task automatic settle(input string name);
        repeat (5) @(negedge clock);
        $display("test %s done", name);
    endtask
    initial
    begin
        void'($urandom(32'hbbcd));
        repeat (12) @(negedge clock);
        rst = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clock);
            user_out = $urandom;
            oe_rnd = $urandom;
            repeat (5) @(negedge clock);
            check(pin_oe, user_oe, "user enable");
            check(pin_out, user_out, "user drive");
            check(user_in & user_oe, user_out & user_oe, "user input");
        end
        settle("user mode");
        en = 1'b1;
        settle("enable");
        check(pin_oe, 4'h8, "port enable");
        check(port_active, 1'b1, "port active");
        src.tmsseq(8'h1f, 6);
        load_ir(4'h2);
        w = $urandom;
        s0 = strobes;
        dr(32, w);
        settle("program");
        check(program_word, w, "program word");
        check(strobes - s0, 1, "program strobe");
        capture_word = $urandom;
        load_ir(4'h1);
        dr(32, $urandom);
        check(q, capture_word, "capture shift");
        settle("capture");
        load_ir(4'hf);
        w = $urandom;
        mq = {1'b0};
        for (int i = 0; i < 8; i++)
        begin
            e[i] = mq.pop_front();
            mq.push_back(w[i]);
        end
        dr(8, w);
        check(q[7:0], e[7:0], "bypass chain");
        check(strobes - s0, 1, "no strobe outside program");
        settle("bypass");
        en = 1'b0;
        settle("disable");
        check(pin_oe, user_oe, "release pins");
        check(port_active, 1'b0, "port released");
        legacy_variant = 1'b1;
        en = 1'b1;
        settle("legacy low");
        check(pin_oe, user_oe, "legacy without supervoltage");
        check(port_active, 1'b0, "legacy inactive");
        supv = 1'b1;
        settle("legacy high");
        check(pin_oe, 4'h8, "legacy with supervoltage");
        check(port_active, 1'b1, "legacy active");
        print_verdict();
    end
endmodule
`default_nettype wire
